// File: src/baro_regs_pkg.sv
package baro_regs_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [6:0] ADDR_INTERRUPT_CONFIG      = 7'h0B;
  localparam logic [6:0] ADDR_THRESHOLD_LOW         = 7'h0C;
  localparam logic [6:0] ADDR_THRESHOLD_HIGH        = 7'h0D;
  localparam logic [6:0] ADDR_DEVICE_IDENTITY       = 7'h0F;
  localparam logic [6:0] ADDR_CONTROL_ONE           = 7'h10;
  localparam logic [6:0] ADDR_CONTROL_TWO           = 7'h11;
  localparam logic [6:0] ADDR_INTERRUPT_CONTROL     = 7'h12;
  localparam logic [6:0] ADDR_QUEUE_CONTROL         = 7'h14;
  localparam logic [6:0] ADDR_REFERENCE_XLOW        = 7'h15;
  localparam logic [6:0] ADDR_REFERENCE_LOW         = 7'h16;
  localparam logic [6:0] ADDR_REFERENCE_HIGH        = 7'h17;
  localparam logic [6:0] ADDR_OFFSET_LOW            = 7'h18;
  localparam logic [6:0] ADDR_OFFSET_HIGH           = 7'h19;
  localparam logic [6:0] ADDR_RESOLUTION_CONFIG     = 7'h1A;
  localparam logic [6:0] ADDR_INTERRUPT_ORIGIN      = 7'h25;
  localparam logic [6:0] ADDR_QUEUE_STATE           = 7'h26;
  localparam logic [6:0] ADDR_SENSOR_STATUS         = 7'h27;
  localparam logic [6:0] ADDR_PRESSURE_XLOW         = 7'h28;
  localparam logic [6:0] ADDR_PRESSURE_LOW          = 7'h29;
  localparam logic [6:0] ADDR_PRESSURE_HIGH         = 7'h2A;
  localparam logic [6:0] ADDR_TEMPERATURE_LOW       = 7'h2B;
  localparam logic [6:0] ADDR_TEMPERATURE_HIGH      = 7'h2C;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RESET_ZERO                 = 8'h00;
  localparam logic [7:0] RESET_CONTROL_TWO          = 8'h10;
  localparam logic [6:0] RESET_ADDRESS              = 7'h00;
  // Identity code value is arbitrary.
  localparam logic [7:0] IDENTITY_VALUE             = 8'h5A;

  // ==========================================================================
  // Interrupt configuration field positions.
  localparam int BIT_AUTO_REFERENCE_ENABLE          = 7;
  localparam int BIT_AUTO_REFERENCE_RESET           = 6;
  localparam int BIT_AUTOZERO_ENABLE                = 5;
  localparam int BIT_AUTOZERO_RESET                 = 4;
  localparam int BIT_DIFFERENTIAL_INTERRUPT_ENABLE  = 3;
  localparam int BIT_LATCH_REQUEST                  = 2;
  localparam int BIT_LOW_PRESSURE_EVENT_ENABLE      = 1;
  localparam int BIT_HIGH_PRESSURE_EVENT_ENABLE     = 0;

  // Sub-address field: top bit asks for address advance.
  localparam int BIT_SUB_ADVANCE                    = 7;

endpackage

// File: src/barometer_register_map.sv
// Notes on behaviour
// - Every register is one byte per access.
// - Seven-bit address selects the register.
// - Interrupt config read/write, resets zero, eight fields.
// - Pressure three bytes, temperature two, consecutive.
// - Sub-address top bit advances address per byte.
module barometer_register_map (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Byte port from the serial slave.
  input  wire logic       sub_load,
  input  wire logic [7:0] sub_byte,
  input  wire logic       write_strobe,
  input  wire logic [7:0] write_data,
  input  wire logic       read_strobe,
  output logic      [7:0] read_data,
  output logic      [6:0] current_address,
  // Live values from the measurement chain.
  input  wire logic [7:0] interrupt_origin_in,
  input  wire logic [7:0] queue_state_in,
  input  wire logic [7:0] sensor_status_in,
  input  wire logic [23:0] pressure_in,
  input  wire logic [15:0] temperature_in,
  // Configuration outputs.
  output logic      [7:0] interrupt_config,
  output logic      [15:0] pressure_threshold,
  output logic      [7:0] control_one,
  output logic      [7:0] control_two,
  output logic      [7:0] interrupt_control,
  output logic      [7:0] queue_control,
  output logic      [23:0] reference_pressure,
  output logic      [15:0] pressure_offset,
  output logic      [7:0] resolution_config,
  // Decoded interrupt configuration fields.
  output logic            auto_reference_enable,
  output logic            auto_reference_reset,
  output logic            autozero_enable,
  output logic            autozero_reset,
  output logic            differential_interrupt_enable,
  output logic            latch_request,
  output logic            low_pressure_event_enable,
  output logic            high_pressure_event_enable
);

  // ==========================================================================
  // Address pointer.
  logic       advance;
  logic       access;

  assign access = write_strobe | read_strobe;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      current_address <= baro_regs_pkg::RESET_ADDRESS;
      advance         <= 1'b0;
    end else if (sub_load) begin
      current_address <= sub_byte[6:0];
      advance         <= sub_byte[baro_regs_pkg::BIT_SUB_ADVANCE];
    end else if (access && advance) begin
      current_address <= current_address + 7'h01;
    end
  end

  // ==========================================================================
  // Writable registers.
  // Reset reloads the stored defaults. Each register has its own write
  // decode, so read-only, reserved and unlisted addresses simply drop the
  // byte: there is nothing behind them to disturb.
  logic wr;
  assign wr = write_strobe && !sub_load;

  // ==========================================================================
  // Interrupt configuration.
  logic       write_interrupt_config;

  assign write_interrupt_config =
    wr && (current_address == baro_regs_pkg::ADDR_INTERRUPT_CONFIG);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_config <= baro_regs_pkg::RESET_ZERO;
    end else if (write_interrupt_config) begin
      interrupt_config <= write_data;
    end
  end

  // ==========================================================================
  // Pressure threshold, low byte.
  logic       write_threshold_low;
  logic [7:0] threshold_low;

  assign write_threshold_low =
    wr && (current_address == baro_regs_pkg::ADDR_THRESHOLD_LOW);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      threshold_low <= baro_regs_pkg::RESET_ZERO;
    end else if (write_threshold_low) begin
      threshold_low <= write_data;
    end
  end

  // ==========================================================================
  // Pressure threshold, high byte.
  logic       write_threshold_high;
  logic [7:0] threshold_high;

  assign write_threshold_high =
    wr && (current_address == baro_regs_pkg::ADDR_THRESHOLD_HIGH);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      threshold_high <= baro_regs_pkg::RESET_ZERO;
    end else if (write_threshold_high) begin
      threshold_high <= write_data;
    end
  end

  // ==========================================================================
  // Control one.
  logic       write_control_one;

  assign write_control_one =
    wr && (current_address == baro_regs_pkg::ADDR_CONTROL_ONE);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_one <= baro_regs_pkg::RESET_ZERO;
    end else if (write_control_one) begin
      control_one <= write_data;
    end
  end

  // ==========================================================================
  // Control two.
  logic       write_control_two;

  assign write_control_two =
    wr && (current_address == baro_regs_pkg::ADDR_CONTROL_TWO);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_two <= baro_regs_pkg::RESET_CONTROL_TWO;
    end else if (write_control_two) begin
      control_two <= write_data;
    end
  end

  // ==========================================================================
  // Interrupt control.
  logic       write_interrupt_control;

  assign write_interrupt_control =
    wr && (current_address == baro_regs_pkg::ADDR_INTERRUPT_CONTROL);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_control <= baro_regs_pkg::RESET_ZERO;
    end else if (write_interrupt_control) begin
      interrupt_control <= write_data;
    end
  end

  // ==========================================================================
  // Queue control.
  logic       write_queue_control;

  assign write_queue_control =
    wr && (current_address == baro_regs_pkg::ADDR_QUEUE_CONTROL);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      queue_control <= baro_regs_pkg::RESET_ZERO;
    end else if (write_queue_control) begin
      queue_control <= write_data;
    end
  end

  // ==========================================================================
  // Reference pressure, lowest byte.
  logic       write_reference_xlow;
  logic [7:0] reference_xlow;

  assign write_reference_xlow =
    wr && (current_address == baro_regs_pkg::ADDR_REFERENCE_XLOW);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reference_xlow <= baro_regs_pkg::RESET_ZERO;
    end else if (write_reference_xlow) begin
      reference_xlow <= write_data;
    end
  end

  // ==========================================================================
  // Reference pressure, middle byte.
  logic       write_reference_low;
  logic [7:0] reference_low;

  assign write_reference_low =
    wr && (current_address == baro_regs_pkg::ADDR_REFERENCE_LOW);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reference_low <= baro_regs_pkg::RESET_ZERO;
    end else if (write_reference_low) begin
      reference_low <= write_data;
    end
  end

  // ==========================================================================
  // Reference pressure, high byte.
  logic       write_reference_high;
  logic [7:0] reference_high;

  assign write_reference_high =
    wr && (current_address == baro_regs_pkg::ADDR_REFERENCE_HIGH);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reference_high <= baro_regs_pkg::RESET_ZERO;
    end else if (write_reference_high) begin
      reference_high <= write_data;
    end
  end

  // ==========================================================================
  // Pressure offset, low byte.
  logic       write_offset_low;
  logic [7:0] offset_low;

  assign write_offset_low =
    wr && (current_address == baro_regs_pkg::ADDR_OFFSET_LOW);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      offset_low <= baro_regs_pkg::RESET_ZERO;
    end else if (write_offset_low) begin
      offset_low <= write_data;
    end
  end

  // ==========================================================================
  // Pressure offset, high byte.
  logic       write_offset_high;
  logic [7:0] offset_high;

  assign write_offset_high =
    wr && (current_address == baro_regs_pkg::ADDR_OFFSET_HIGH);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      offset_high <= baro_regs_pkg::RESET_ZERO;
    end else if (write_offset_high) begin
      offset_high <= write_data;
    end
  end

  // ==========================================================================
  // Resolution configuration.
  logic       write_resolution_config;

  assign write_resolution_config =
    wr && (current_address == baro_regs_pkg::ADDR_RESOLUTION_CONFIG);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      resolution_config <= baro_regs_pkg::RESET_ZERO;
    end else if (write_resolution_config) begin
      resolution_config <= write_data;
    end
  end

  // ==========================================================================
  // Multi-byte settings leave the block as whole words.
  assign pressure_threshold = {threshold_high, threshold_low};
  assign reference_pressure = {reference_high, reference_low, reference_xlow};
  assign pressure_offset    = {offset_high, offset_low};

  // ==========================================================================
  // Interrupt configuration fields.
  assign auto_reference_enable         =
    interrupt_config[baro_regs_pkg::BIT_AUTO_REFERENCE_ENABLE];
  assign auto_reference_reset          =
    interrupt_config[baro_regs_pkg::BIT_AUTO_REFERENCE_RESET];
  assign autozero_enable               =
    interrupt_config[baro_regs_pkg::BIT_AUTOZERO_ENABLE];
  assign autozero_reset                =
    interrupt_config[baro_regs_pkg::BIT_AUTOZERO_RESET];
  assign differential_interrupt_enable =
    interrupt_config[baro_regs_pkg::BIT_DIFFERENTIAL_INTERRUPT_ENABLE];
  assign latch_request                 =
    interrupt_config[baro_regs_pkg::BIT_LATCH_REQUEST];
  assign low_pressure_event_enable     =
    interrupt_config[baro_regs_pkg::BIT_LOW_PRESSURE_EVENT_ENABLE];
  assign high_pressure_event_enable    =
    interrupt_config[baro_regs_pkg::BIT_HIGH_PRESSURE_EVENT_ENABLE];

  // ==========================================================================
  // Read path.
  // Data is registered when the strobe arrives, so the byte stands still
  // while the serial slave shifts it out.
  logic [7:0] next_read_data;

  always_comb begin
    unique case (current_address)
      baro_regs_pkg::ADDR_INTERRUPT_CONFIG:  next_read_data = interrupt_config;
      baro_regs_pkg::ADDR_THRESHOLD_LOW:     next_read_data = pressure_threshold[7:0];
      baro_regs_pkg::ADDR_THRESHOLD_HIGH:    next_read_data = pressure_threshold[15:8];
      baro_regs_pkg::ADDR_DEVICE_IDENTITY:   next_read_data = baro_regs_pkg::IDENTITY_VALUE;
      baro_regs_pkg::ADDR_CONTROL_ONE:       next_read_data = control_one;
      baro_regs_pkg::ADDR_CONTROL_TWO:       next_read_data = control_two;
      baro_regs_pkg::ADDR_INTERRUPT_CONTROL: next_read_data = interrupt_control;
      baro_regs_pkg::ADDR_QUEUE_CONTROL:     next_read_data = queue_control;
      baro_regs_pkg::ADDR_REFERENCE_XLOW:    next_read_data = reference_pressure[7:0];
      baro_regs_pkg::ADDR_REFERENCE_LOW:     next_read_data = reference_pressure[15:8];
      baro_regs_pkg::ADDR_REFERENCE_HIGH:    next_read_data = reference_pressure[23:16];
      baro_regs_pkg::ADDR_OFFSET_LOW:        next_read_data = pressure_offset[7:0];
      baro_regs_pkg::ADDR_OFFSET_HIGH:       next_read_data = pressure_offset[15:8];
      baro_regs_pkg::ADDR_RESOLUTION_CONFIG: next_read_data = resolution_config;
      baro_regs_pkg::ADDR_INTERRUPT_ORIGIN:  next_read_data = interrupt_origin_in;
      baro_regs_pkg::ADDR_QUEUE_STATE:       next_read_data = queue_state_in;
      baro_regs_pkg::ADDR_SENSOR_STATUS:     next_read_data = sensor_status_in;
      baro_regs_pkg::ADDR_PRESSURE_XLOW:     next_read_data = pressure_in[7:0];
      baro_regs_pkg::ADDR_PRESSURE_LOW:      next_read_data = pressure_in[15:8];
      baro_regs_pkg::ADDR_PRESSURE_HIGH:     next_read_data = pressure_in[23:16];
      baro_regs_pkg::ADDR_TEMPERATURE_LOW:   next_read_data = temperature_in[7:0];
      baro_regs_pkg::ADDR_TEMPERATURE_HIGH:  next_read_data = temperature_in[15:8];
      default:                               next_read_data = baro_regs_pkg::RESET_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= baro_regs_pkg::RESET_ZERO;
    end else if (read_strobe && !sub_load) begin
      read_data <= next_read_data;
    end
  end

endmodule

// File: sim/baro_checker.sv
// ====
// Checker on the register map ports.
module baro_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        sub_load,
  input wire logic  [7:0] sub_byte,
  input wire logic        write_strobe,
  input wire logic  [7:0] write_data,
  input wire logic        read_strobe,
  input wire logic  [7:0] read_data,
  input wire logic  [6:0] current_address,
  input wire logic [23:0] pressure_in,
  input wire logic  [7:0] interrupt_config,
  input wire logic  [7:0] control_one,
  input wire logic  [7:0] control_two,
  input wire logic        auto_reference_enable,
  input wire logic        high_pressure_event_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic       adv;
  logic       wr;
  logic       rd;
  logic [7:0] plo;
  assign wr = !sub_load && write_strobe;
  assign rd = !sub_load && read_strobe;
  assign plo = pressure_in[7:0];
  // Tracks the advance request so stepping can be judged per strobe.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) adv <= 1'b0;
    else if (sub_load) adv <= sub_byte[7];
  end
  addr_load_a: assert property (sub_load |=>
    {1'b0, current_address} == ($past(sub_byte) & 8'h7F)) else $error("address not loaded");
  addr_step_a: assert property ((wr || rd) && adv |=>
    current_address == $past(current_address) + 7'h01) else $error("address did not step");
  addr_hold_a: assert property (!sub_load && !adv |=>
    $stable(current_address)) else $error("address moved without advance");
  cfg_write_a: assert property (wr && current_address == 7'h0B |=>
    interrupt_config == $past(write_data)) else $error("config write lost");
  cfg_fields_a: assert property (auto_reference_enable == interrupt_config[7] &&
    high_pressure_event_enable == interrupt_config[0]) else $error("field order wrong");
  id_read_a: assert property (rd && current_address == 7'h0F |=>
    read_data == baro_regs_pkg::IDENTITY_VALUE) else $error("identity read wrong");
  press_read_a: assert property (rd && current_address == 7'h28 |=>
    read_data == $past(plo)) else $error("pressure byte wrong");
  ro_write_a: assert property (wr && current_address inside {[7'h25:7'h2C], 7'h0F} |=>
    $stable(interrupt_config) && $stable(control_one) && $stable(control_two))
    else $error("read-only write had effect");
  reset_val_a: assert property ($rose(reset_n) |->
    interrupt_config == 8'h00 && control_two == 8'h10) else $error("reset value wrong");
  cover property (wr && current_address == 7'h0B);
  cover property (rd && adv);
  cover property (rd && current_address == 7'h2C);
endmodule
bind barometer_register_map baro_checker chk (.*);

// File: sim/host_model.sv
// ====
// Host side of the byte port.
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] read_data,
  output logic            sub_load,
  output logic      [7:0] sub_byte,
  output logic            write_strobe,
  output logic      [7:0] write_data,
  output logic            read_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {sub_load, write_strobe, read_strobe} = 3'h0;
    sub_byte = 8'h00;
    write_data = 8'h00;
  end
  // Idle lines are inverted so a stale byte never passes for a live one.
  task automatic pick(input logic [7:0] sb);
    @(posedge mclk);
    sub_load <= 1'b1;
    sub_byte <= sb;
    @(posedge mclk);
    sub_load <= 1'b0;
    sub_byte <= ~sb;
  endtask
  task automatic xfer(input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    write_strobe <= w;
    read_strobe <= !w;
    write_data <= d;
    @(posedge mclk);
    write_strobe <= 1'b0;
    read_strobe <= 1'b0;
    write_data <= ~d;
    #1 q = read_data;
  endtask
endmodule

// File: sim/barometer_register_map_tb.sv
// ====
// Bench for the register map.
module barometer_register_map_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, sub_load, write_strobe, read_strobe, auto_reference_enable;
  logic auto_reference_reset, autozero_enable, autozero_reset, differential_interrupt_enable;
  logic latch_request, low_pressure_event_enable, high_pressure_event_enable;
  logic [7:0] sub_byte, write_data, read_data, q, interrupt_config, control_one, control_two;
  logic [7:0] interrupt_control, queue_control, resolution_config, interrupt_origin_in;
  logic [7:0] queue_state_in, sensor_status_in;
  logic [6:0] current_address;
  logic [15:0] pressure_threshold, pressure_offset, temperature_in;
  logic [23:0] reference_pressure, pressure_in;
  int fails, total_checks, cyc;
  logic [6:0] rw [13] = '{7'h0B, 7'h0C, 7'h0D, 7'h10, 7'h11, 7'h12, 7'h14, 7'h15,
                          7'h16, 7'h17, 7'h18, 7'h19, 7'h1A};
  // Reserved places are only read, never written.
  logic [6:0] ro [6] = '{7'h0F, 7'h25, 7'h26, 7'h27, 7'h0E, 7'h13};
  logic [7:0] rox [6] = '{baro_regs_pkg::IDENTITY_VALUE, 8'h3C, 8'h4D, 8'h5E, 8'h00, 8'h00};
  barometer_register_map dut (.*);
  host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      $display("[FAIL] t=%0t timeout cycles=%h limit=%h", $time, cyc, 2000);
      fails++;
      final_report;
    end
  end
  initial begin
    reset_n = 1'b0;
    {interrupt_origin_in, queue_state_in, sensor_status_in} = 24'h3C4D5E;
    pressure_in = 24'hA1B2C3;
    temperature_in = 16'hD4E5;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rw[i]) begin
      host.pick({1'b0, rw[i]});
      host.xfer(1'b0, 8'h00, q);
      chk(q, rw[i] == 7'h11 ? 8'h10 : 8'h00);
    end
    $display("reset values done");
    foreach (rw[i]) begin
      host.pick({1'b0, rw[i]});
      host.xfer(1'b1, {1'b1, rw[i]}, q);
      host.xfer(1'b0, 8'h00, q);
      chk(q, {1'b1, rw[i]});
    end
    chk(reference_pressure, 24'h979695);
    chk({pressure_offset, resolution_config}, 24'h99989A);
    chk({control_one, control_two, interrupt_control}, 24'h909192);
    chk({queue_control, pressure_threshold}, 24'h948D8C);
    $display("write readback done");
    host.pick(8'h8B);
    for (int i = 0; i < 3; i++) host.xfer(1'b1, 8'h61 + i[7:0], q);
    chk(pressure_threshold, 16'h6362);
    chk({auto_reference_enable, auto_reference_reset, autozero_enable, autozero_reset,
         differential_interrupt_enable, latch_request, low_pressure_event_enable,
         high_pressure_event_enable}, 8'h61);
    host.pick(8'hA8);
    for (int i = 0; i < 5; i++) begin
      host.xfer(1'b0, 8'h00, q);
      chk(q, 8'({temperature_in, pressure_in} >> (8 * i)));
    end
    $display("burst access done");
    foreach (ro[i]) begin
      host.pick({1'b0, ro[i]});
      if (i < 4) host.xfer(1'b1, 8'hFF, q);
      host.xfer(1'b0, 8'h00, q);
      chk(q, rox[i]);
    end
    chk(interrupt_config, 8'h61);
    $display("read-only places done");
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    chk({1'b0, current_address, interrupt_config}, 24'h000000);
    host.pick(8'h11);
    host.xfer(1'b0, 8'h00, q);
    chk(q, 8'h10);
    $display("mid-run reset done");
    final_report;
  end
endmodule
